// ==== hdl/fifo_irq_params.svh ====
// constants for the fifo and waveform interrupt autovector block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef FIFO_IRQ_PARAMS_SVH
`define FIFO_IRQ_PARAMS_SVH

`define NUM_SOURCES      14
`define VECTOR_BASE      8'h80
`define VECTOR_STEP      8'h04
`define ENTRY_ADDR       16'h0053
`define PAGE_ADDR        16'h0054
`define VECTOR_ADDR      16'h0055
`define REG_ENABLE       4'h0
`define REG_SETUP        4'h1
`define REG_STATUS       4'h2
`define REG_VECTOR       4'h3
`define SETUP_AV_BIT     0
`define ENABLE_RESET     14'h0000
`define SETUP_RESET      8'h00

`endif

// ==== hdl/fifo_irq_pkg.sv ====
// types shared by the fifo and waveform interrupt block
package fifo_irq_pkg;
   typedef logic [13:0] src_vec_t;
   typedef logic [7:0]  byte_t;
   typedef logic [3:0]  reg_addr_t;
endpackage : fifo_irq_pkg

// ==== hdl/source_sync.sv ====
// two flop synchroniser plus rising edge detector for one source
module source_sync (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_async,
   output logic      o_level,
   output logic      o_rise
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign o_level = sync_ff;
   assign o_rise  = sync_ff & ~prev_ff;
endmodule : source_sync

// ==== hdl/fifo_waveform_irq_autovector.sv ====
// priority interrupt selector with autovector byte substitution
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "fifo_irq_params.svh"

module fifo_waveform_irq_autovector (
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // event sources, asynchronous to the core clock
   input  wire logic        i_endpoint_two_level_flag,
   input  wire logic        i_endpoint_four_level_flag,
   input  wire logic        i_endpoint_six_level_flag,
   input  wire logic        i_endpoint_eight_level_flag,
   input  wire logic        i_endpoint_two_empty_flag,
   input  wire logic        i_endpoint_four_empty_flag,
   input  wire logic        i_endpoint_six_empty_flag,
   input  wire logic        i_endpoint_eight_empty_flag,
   input  wire logic        i_endpoint_two_full_flag,
   input  wire logic        i_endpoint_four_full_flag,
   input  wire logic        i_endpoint_six_full_flag,
   input  wire logic        i_endpoint_eight_full_flag,
   input  wire logic        i_waveform_engine_done,
   input  wire logic        i_waveform_engine_event,
   // core code fetch path
   input  wire logic [15:0] i_fetch_addr,
   input  wire logic        i_fetch_strobe,
   input  wire logic [7:0]  i_mem_byte,
   output logic      [7:0]  o_fetch_byte,
   output logic             o_fetch_valid,
   output logic [15:0]      o_entry_addr,
   // register port
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   // interrupt request to the core
   output logic             o_irq
);

   //-------------------------------------------------------------------
   // source synchronisers
   //-------------------------------------------------------------------
   fifo_irq_pkg::src_vec_t raw_src;
   fifo_irq_pkg::src_vec_t src_level;
   fifo_irq_pkg::src_vec_t src_rise;

   // bit index equals priority minus one
   assign raw_src = {i_waveform_engine_event,    i_waveform_engine_done,
                     i_endpoint_eight_full_flag, i_endpoint_six_full_flag,
                     i_endpoint_four_full_flag,  i_endpoint_two_full_flag,
                     i_endpoint_eight_empty_flag, i_endpoint_six_empty_flag,
                     i_endpoint_four_empty_flag, i_endpoint_two_empty_flag,
                     i_endpoint_eight_level_flag, i_endpoint_six_level_flag,
                     i_endpoint_four_level_flag, i_endpoint_two_level_flag};

   // pins are on other clocks, so each passes two flops before any logic
   genvar g;
   generate
      for (g = 0; g < `NUM_SOURCES; g++) begin : g_sync
         source_sync u_sync (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_async (raw_src[g]),
            .o_level (src_level[g]),
            .o_rise  (src_rise[g])
         );
      end
   endgenerate

   //-------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------
   fifo_irq_pkg::src_vec_t enable_ff;
   fifo_irq_pkg::src_vec_t status_ff;
   fifo_irq_pkg::byte_t    setup_ff;
   fifo_irq_pkg::src_vec_t wr_clear;
   logic                   autovector_enable;

   assign autovector_enable = setup_ff[`SETUP_AV_BIT];
   assign wr_clear = (i_reg_wr && i_reg_addr == `REG_STATUS) ? i_reg_wdata[13:0] : '0;

   // enable mask, software written
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enable_ff <= `ENABLE_RESET;
      end else if (i_reg_wr && i_reg_addr == `REG_ENABLE) begin
         enable_ff <= i_reg_wdata[13:0];
      end
   end

   // interrupt setup register, holds the autovector enable
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         setup_ff <= `SETUP_RESET;
      end else if (i_reg_wr && i_reg_addr == `REG_SETUP) begin
         setup_ff <= i_reg_wdata[7:0];
      end
   end

   // sticky status, write one to clear; a new edge wins over the clear
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         status_ff <= '0;
      end else begin
         status_ff <= (status_ff & ~wr_clear) | src_rise;
      end
   end

   //-------------------------------------------------------------------
   // priority encoder
   //-------------------------------------------------------------------
   fifo_irq_pkg::src_vec_t pending;
   fifo_irq_pkg::byte_t    nxt_vector;
   logic                   any_pending;

   assign pending     = status_ff & enable_ff;
   assign any_pending = |pending;

   // lowest bit wins, so endpoint two level flag is the top source
   always_comb begin
      nxt_vector = `VECTOR_BASE;
      for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
         if (pending[i]) begin
            nxt_vector = 8'(`VECTOR_BASE + (i << 2));
         end
      end
   end

   fifo_irq_pkg::byte_t vector_ff;
   logic                irq_ff;

   // vector tracks the best pending source each cycle
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         vector_ff <= `VECTOR_BASE;
         irq_ff    <= 1'b0;
      end else begin
         vector_ff <= nxt_vector;
         irq_ff    <= any_pending;
      end
   end

   assign o_irq        = irq_ff;
   assign o_entry_addr = `ENTRY_ADDR; // core pushes pc and enters here

   //-------------------------------------------------------------------
   // fetch substitution
   //-------------------------------------------------------------------
   fifo_irq_pkg::byte_t fetch_ff;
   logic                fetch_valid_ff;
   logic                substitute;

   // only the byte after the page byte is replaced; page and jump come from memory
   assign substitute = autovector_enable && i_fetch_addr == `VECTOR_ADDR;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fetch_ff       <= 8'h00;
         fetch_valid_ff <= 1'b0;
      end else begin
         fetch_valid_ff <= i_fetch_strobe;
         if (i_fetch_strobe) begin
            fetch_ff <= substitute ? nxt_vector : i_mem_byte;
         end
      end
   end

   assign o_fetch_byte  = fetch_ff;
   assign o_fetch_valid = fetch_valid_ff;

   //-------------------------------------------------------------------
   // register read port
   //-------------------------------------------------------------------
   logic [15:0] rdata_ff;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_ff <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `REG_ENABLE: rdata_ff <= {2'b00, enable_ff};
            `REG_SETUP:  rdata_ff <= {8'h00, setup_ff};
            `REG_STATUS: rdata_ff <= {2'b00, status_ff};
            `REG_VECTOR: rdata_ff <= {irq_ff, 7'h00, vector_ff};
            default:     rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign o_reg_rdata = rdata_ff;

   //-------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------
   chk_top_source_vec: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      pending[0] |=> vector_ff == 8'h80)
      else $error("top source did not give vector 80");

   chk_empty_rank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[7:0] == 8'h10) |=> vector_ff == 8'h90)
      else $error("endpoint two empty flag vector wrong");

   chk_full_rank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[11:0] == 12'h800) |=> vector_ff == 8'hac)
      else $error("endpoint eight full flag vector wrong");

   chk_waveform_last: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending == 14'h2000) |=> vector_ff == 8'hb4)
      else $error("waveform event vector wrong");

   // the remaining ends of each rank plus endpoint four level flag, so a swap that moves an end of a rank shows up
   chk_second_rank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[1:0] == 2'b10) |=> vector_ff == 8'h84)
      else $error("endpoint four level flag vector wrong");

   chk_level_rank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[3:0] == 4'h8) |=> vector_ff == 8'h8c)
      else $error("endpoint eight level flag vector wrong");

   chk_empty_last: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[7:0] == 8'h80) |=> vector_ff == 8'h9c)
      else $error("endpoint eight empty flag vector wrong");

   chk_full_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[8:0] == 9'h100) |=> vector_ff == 8'ha0)
      else $error("endpoint two full flag vector wrong");

   chk_done_rank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending[12:0] == 13'h1000) |=> vector_ff == 8'hb0)
      else $error("waveform done vector wrong");

   chk_idle_vector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pending == '0) |=> vector_ff == 8'h80)
      else $error("idle vector is not the base value");

   chk_autovector_sub: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_fetch_strobe && autovector_enable && i_fetch_addr == 16'h0055)
      |=> o_fetch_valid && o_fetch_byte == $past(nxt_vector))
      else $error("autovector byte not substituted");

   chk_page_plain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_fetch_strobe && i_fetch_addr == 16'h0054) |=> o_fetch_byte == $past(i_mem_byte))
      else $error("page byte was altered");

   chk_vector_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      vector_ff[1:0] == 2'b00 && vector_ff >= 8'h80 && vector_ff <= 8'hb4)
      else $error("vector outside the fourteen entries");

   chk_irq_rises: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      any_pending |=> o_irq)
      else $error("interrupt request missing while a source pends");

   chk_irq_falls: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !any_pending |=> !o_irq)
      else $error("interrupt request stands with nothing pending");

   chk_plain_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_fetch_strobe && !autovector_enable) |=> o_fetch_byte == $past(i_mem_byte))
      else $error("substitution while autovector off");

   //-------------------------------------------------------------------
   // checks on fetch timing, sticky status and the register port
   //-------------------------------------------------------------------
   // valid is a one cycle echo of the strobe
   chk_valid_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_fetch_strobe |=> o_fetch_valid)
      else $error("fetch valid missing after strobe");

   chk_valid_drops: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_fetch_strobe |=> !o_fetch_valid)
      else $error("fetch valid without a strobe");

   // the byte must hold for a core that samples it late
   chk_byte_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_fetch_strobe |=> $stable(o_fetch_byte))
      else $error("fetched byte changed without a strobe");

   // status bits only leave by a write of one
   chk_status_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (wr_clear == '0) |=> (status_ff & $past(status_ff)) == $past(status_ff))
      else $error("status bit lost without a clear");

   chk_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (src_rise != '0) |=> (status_ff & $past(src_rise)) == $past(src_rise))
      else $error("source edge did not set its status bit");

   chk_clear_lands: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (wr_clear != '0) |=> (status_ff & $past(wr_clear & ~src_rise)) == '0)
      else $error("status bit survived its clear");

   chk_setup_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_reg_wr && i_reg_addr == 4'h1) |=> autovector_enable == $past(i_reg_wdata[0]))
      else $error("autovector enable not written");

   // idle read data is zero so the port can be or-ed onto a shared bus
   chk_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_reg_rd |=> o_reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");

   chk_vector_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_reg_rd && i_reg_addr == 4'h3)
      |=> o_reg_rdata == {$past(irq_ff), 7'h00, $past(vector_ff)})
      else $error("vector register read wrong");

endmodule : fifo_waveform_irq_autovector

// ==== verification/core_fetch_model.sv ====
// behavioural model of the core side that fetches the interrupt entry bytes
`include "fifo_irq_params.svh"

module core_fetch_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_fetch_byte,
   output logic      [15:0] o_fetch_addr,
   output logic             o_fetch_strobe,
   output logic      [7:0]  o_mem_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] JUMP_OP  = 8'h02; // arbitrary jump opcode
   localparam logic [7:0] PAGE_HI  = 8'h12; // table page preloaded by software
   localparam logic [7:0] PLAIN_55 = 8'h5a; // ordinary memory byte after the page

   initial begin
      o_fetch_addr   = 16'h0000;
      o_fetch_strobe = 1'b0;
   end

   // memory image; elsewhere a pattern that follows the address so no stale byte shows
   always_comb begin
      case (o_fetch_addr)
         `ENTRY_ADDR: o_mem_byte = JUMP_OP;
         `PAGE_ADDR: o_mem_byte = PAGE_HI;
         `VECTOR_ADDR: o_mem_byte = PLAIN_55;
         default: o_mem_byte = ~o_fetch_addr[7:0];
      endcase
   end

   // one fetch: strobe for one cycle, byte taken in the cycle after
   task automatic fetch(input logic [15:0] a, output logic [7:0] b);
      @(posedge i_clk);
      o_fetch_addr   <= a;
      o_fetch_strobe <= 1'b1;
      @(posedge i_clk);
      o_fetch_strobe <= 1'b0;
      o_fetch_addr   <= ~a;
      #1 b = i_fetch_byte;
   endtask : fetch
endmodule : core_fetch_model

// ==== verification/fifo_waveform_irq_autovector_tb.sv ====
// self-checking testbench for the interrupt autovector selector
`include "fifo_irq_params.svh"

module fifo_waveform_irq_autovector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [3:0] idx; logic [7:0] vec;} row_s;
   logic        i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_fetch_strobe, o_fetch_valid, o_irq;
   logic [13:0] src;
   logic [15:0] i_fetch_addr, o_entry_addr, i_reg_wdata, o_reg_rdata, rd;
   logic [7:0]  i_mem_byte, o_fetch_byte, got;
   logic [3:0]  i_reg_addr;
   int          error_cnt, total_checks, cyc;
   row_s        rows [14] = '{'{4'h0, 8'h80}, '{4'h1, 8'h84}, '{4'h2, 8'h88}, '{4'h3, 8'h8c},
      '{4'h4, 8'h90}, '{4'h5, 8'h94}, '{4'h6, 8'h98}, '{4'h7, 8'h9c}, '{4'h8, 8'ha0},
      '{4'h9, 8'ha4}, '{4'ha, 8'ha8}, '{4'hb, 8'hac}, '{4'hc, 8'hb0}, '{4'hd, 8'hb4}};

   fifo_waveform_irq_autovector i_fifo_waveform_irq_autovector (.i_clk(i_clk),
      .i_rst_b(i_rst_b), .i_endpoint_two_level_flag(src[0]),
      .i_endpoint_four_level_flag(src[1]), .i_endpoint_six_level_flag(src[2]),
      .i_endpoint_eight_level_flag(src[3]), .i_endpoint_two_empty_flag(src[4]),
      .i_endpoint_four_empty_flag(src[5]), .i_endpoint_six_empty_flag(src[6]),
      .i_endpoint_eight_empty_flag(src[7]), .i_endpoint_two_full_flag(src[8]),
      .i_endpoint_four_full_flag(src[9]), .i_endpoint_six_full_flag(src[10]),
      .i_endpoint_eight_full_flag(src[11]), .i_waveform_engine_done(src[12]),
      .i_waveform_engine_event(src[13]), .i_fetch_addr(i_fetch_addr),
      .i_fetch_strobe(i_fetch_strobe), .i_mem_byte(i_mem_byte), .o_fetch_byte(o_fetch_byte),
      .o_fetch_valid(o_fetch_valid), .o_entry_addr(o_entry_addr), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));

   core_fetch_model i_core_fetch_model (.i_clk(i_clk), .i_fetch_byte(o_fetch_byte),
      .o_fetch_addr(i_fetch_addr), .o_fetch_strobe(i_fetch_strobe), .o_mem_byte(i_mem_byte));

   //----------------------------------------------------------------------
   // clock, timeout and shared tasks
   //----------------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // a hung handshake would otherwise run forever
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_clk);
      i_reg_wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_clk);
      i_reg_rd   <= 1'b0;
      #1 d = o_reg_rdata;
   endtask : reg_rd

   // rising edge on one source; status then irq follow within four edges
   task automatic pulse(input int i);
      @(posedge i_clk);
      src[i] <= 1'b1;
      repeat (4) @(posedge i_clk);
      src[i] <= 1'b0;
      @(posedge i_clk);
      #1;
   endtask : pulse

   task automatic end_of_test();
      if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   //----------------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------------
   initial begin
      {i_rst_b, i_reg_wr, i_reg_rd, src, i_reg_addr, i_reg_wdata} = '0;
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      #1 check(o_entry_addr, `ENTRY_ADDR);
      check({15'h0000, o_irq}, 16'h0000);
      reg_rd(`REG_ENABLE, rd);
      check(rd, {2'b00, `ENABLE_RESET});
      reg_wr(`REG_ENABLE, 16'h3fff);
      reg_wr(`REG_SETUP, 16'h0001);
      i_core_fetch_model.fetch(o_entry_addr, got);
      check({8'h00, got}, 16'h0002);
      foreach (rows[r]) begin
         pulse(rows[r].idx);
         check({15'h0000, o_irq}, 16'h0001);
         i_core_fetch_model.fetch(`VECTOR_ADDR, got);
         check({8'h00, got}, {8'h00, rows[r].vec});
         check({15'h0000, o_fetch_valid}, 16'h0001);
         reg_rd(`REG_VECTOR, rd);
         check(rd, {8'h80, rows[r].vec});
         reg_wr(`REG_STATUS, 16'h0001 << rows[r].idx);
         @(posedge i_clk);
         #1 check({15'h0000, o_irq}, 16'h0000);
      end
      // lowest and highest rank pending together: the highest wins until cleared
      pulse(13);
      pulse(0);
      i_core_fetch_model.fetch(`VECTOR_ADDR, got);
      check({8'h00, got}, 16'h0080);
      reg_wr(`REG_STATUS, 16'h0001);
      i_core_fetch_model.fetch(`VECTOR_ADDR, got);
      check({8'h00, got}, 16'h00b4);
      // autovector off: plain memory bytes come through
      reg_wr(`REG_SETUP, 16'h0000);
      i_core_fetch_model.fetch(`VECTOR_ADDR, got);
      check({8'h00, got}, 16'h005a);
      i_core_fetch_model.fetch(`PAGE_ADDR, got);
      check({8'h00, got}, 16'h0012);
      reg_wr(`REG_STATUS, 16'h3fff);
      // masked source latches status but raises no request
      reg_wr(`REG_ENABLE, 16'h0000);
      pulse(5);
      check({15'h0000, o_irq}, 16'h0000);
      reg_rd(`REG_STATUS, rd);
      check(rd, 16'h0020);
      reg_rd(4'h7, rd);
      check(rd, 16'h0000);
      // a clear and a new edge on one source in the same cycle: the edge wins
      @(posedge i_clk);
      src[1] <= 1'b1;
      @(posedge i_clk);
      reg_wr(`REG_STATUS, 16'h0002);
      reg_rd(`REG_STATUS, rd);
      check(rd, 16'h0022);
      // mid-run reset with a request standing: all state returns to idle
      reg_wr(`REG_ENABLE, 16'h3fff);
      @(posedge i_clk);
      #1 check({15'h0000, o_irq}, 16'h0001);
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      src[1]  <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      #1 check({15'h0000, o_irq}, 16'h0000);
      reg_rd(`REG_STATUS, rd);
      check(rd, 16'h0000);
      reg_rd(`REG_ENABLE, rd);
      check(rd, {2'b00, `ENABLE_RESET});
      end_of_test();
   end
endmodule : fifo_waveform_irq_autovector_tb
